//--- common/fiber_aneg_pkg.sv
// Constants for the fiber auto-negotiation advertisement register block
package fiber_aneg_pkg;

  // Register byte offsets on the Avalon bus
  localparam logic [4:0] CTRL_OFFS     = 5'h00;
  localparam logic [4:0] ADVERT_OFFS   = 5'h04;
  localparam logic [4:0] EFFECT_OFFS   = 5'h08;
  localparam logic [4:0] CONFIG_OFFS   = 5'h10;

  // Control register fields
  localparam int SWRST_BIT    = 15;
  localparam int PWRDN_BIT    = 11;
  localparam int RESTART_BIT  = 9;

  // Config register fields
  localparam int MODE_LSB     = 0;
  localparam int PAUSECTL_BIT = 7;

  // Interface mode encodings
  localparam logic [1:0] MODE_BASEX  = 2'h1;
  localparam logic [1:0] MODE_SGSYS  = 2'h2;
  localparam logic [1:0] MODE_SGMED  = 2'h3;

  // 1000BASE-X layout field positions
  localparam int NP_BIT       = 15;
  localparam int RF_LSB       = 12;
  localparam int PAUSE_LSB    = 7;
  localparam int HD_BIT       = 6;
  localparam int FD_BIT       = 5;
  localparam int LOW_LSB      = 0;

  // SGMII system layout field positions
  localparam int SG_LINK_BIT  = 15;
  localparam int SG_DUP_BIT   = 12;
  localparam int SG_SPD_LSB   = 10;
  localparam int SG_TXP_BIT   = 9;
  localparam int SG_RXP_BIT   = 8;
  localparam int SG_MEDIA_BIT = 7;

  // Reset and fixed values
  localparam logic [1:0]  RF_RST       = 2'h0;
  localparam logic        NP_RST       = 1'h0;
  localparam logic        FD_RST       = 1'h1;
  localparam logic [4:0]  LOW_RST      = 5'h00;
  localparam logic [6:0]  SG_LOW_FIXED = 7'h01;
  localparam logic [15:0] MEDIA_FIXED  = 16'h0001;
  localparam logic [1:0]  MODE_RST     = 2'h1;
  localparam logic        PAUSECTL_RST = 1'h0;

endpackage

//--- hw/apply_event_detect.sv
// Detector for the conditions that make pending advertisement writes effective
`timescale 1ns/10ps
module apply_event_detect (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic swResetPulse,
  input  wire logic restartPulse,
  input  wire logic powerDown,
  input  wire logic fiberLinkUp,
  output logic      applyPulse
);

  logic powerDownPrev_r;
  logic linkPrev_r;

  // Previous levels, reset as powered up with link down so no false edge
  always_ff @(posedge clk) begin
    if (reset) begin
      powerDownPrev_r <= 1'h0;
      linkPrev_r      <= 1'h0;
    end else begin
      powerDownPrev_r <= powerDown;
      linkPrev_r      <= fiberLinkUp;
    end
  end

  assign applyPulse = swResetPulse | restartPulse
                    | (powerDownPrev_r & ~powerDown)
                    | (linkPrev_r & ~fiberLinkUp);

endmodule // apply_event_detect

//--- hw/fiber_aneg_advert_reg.sv
// Fiber auto-negotiation advertisement register with Avalon-MM slave access
`timescale 1ns/10ps

// Functional notes
// - Written advertisement fields stay pending until reset, restart, power-up or link loss.
// - BASE-X bit 15 next page, writable, hardware reset 0, kept on software reset.
// - BASE-X bits 13:12 writable remote fault code; never detected by device.
// - BASE-X bits 8:7 writable pause advertisement code.
// - Hardware reset loads both pause bits from pause strap; software reset keeps.
// - Half-duplex bit 6 hardware reset from negotiation strap bit 0; software reset keeps.
// - Full-duplex bit 5 resets to 1, kept on software reset, deferred apply.
// - Mode 01 selects BASE-X layout, mode 10 selects SGMII system layout.
// - SGMII system bit 15 shows copper link up; resets to 0.
// - SGMII system bit 12 shows resolved duplex, 1 full.
// - SGMII system bits 11:10 show resolved speed code.
// - SGMII transmit and receive pause bits forced 0 when pause control is 0.
// - SGMII bit 7 shows media, fiber 1, forced 0 when pause control 0.
// - Mode 11 reads whole register as fixed 0x0001.
module fiber_aneg_advert_reg (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        pause_strap_default,
  input  wire logic        aneg_config_strap_bit0,
  input  wire logic        fiberLinkUp,
  input  wire logic        copperLinkUp,
  input  wire logic        copperFullDuplex,
  input  wire logic [1:0]  copperSpeed,
  input  wire logic        copperTxPause,
  input  wire logic        copperRxPause,
  input  wire logic        fiberMediaActive,
  output logic      [15:0] effectiveAdvert,
  output logic      [15:0] txConfigWord,
  output logic             swResetPulse,
  output logic             restartPulse,
  output logic             powerDown
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        ack_r;
  logic        accessFire;
  logic        wrFire;
  logic        rdCapture;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;

  logic        pauseSync1_r;
  logic        pauseSync2_r;
  logic        anegSync1_r;
  logic        anegSync2_r;
  logic        strapLoad_r;

  logic        swReset_r;
  logic        restart_r;
  logic        powerDown_r;
  logic [1:0]  mode_r;
  logic        pauseCtl_r;

  logic        nextPage_r;
  logic [1:0]  remoteFault_r;
  logic [1:0]  pauseAdv_r;
  logic        halfDup_r;
  logic        fullDup_r;
  logic [4:0]  lowBits_r;

  logic [15:0] effective_r;
  logic [15:0] sgmiiView_r;
  logic [15:0] writtenView;
  logic [15:0] advertRead;
  logic [15:0] advertWr;
  logic        advertWrEn;
  logic        applyPulse;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake

  // One wait state: read data comes from a flop, address decode is combinational
  assign waitrequest = (read | write) & ~ack_r;
  assign accessFire  = (read | write) & ack_r;
  assign wrFire      = write & ack_r;
  assign rdCapture   = read & ~ack_r;
  assign readdata    = readdata_r;

  // Acknowledge toggles so each access takes exactly two cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // Read data latched in the wait cycle, held until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_r <= 32'h0;
    end else if (rdCapture) begin
      readdata_r <= readdata_nxt;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    readdata_nxt = 32'h0;
    case (address)
      fiber_aneg_pkg::CTRL_OFFS: begin
        readdata_nxt[fiber_aneg_pkg::PWRDN_BIT] = powerDown_r;
      end
      fiber_aneg_pkg::ADVERT_OFFS: begin
        readdata_nxt[15:0] = advertRead;
      end
      fiber_aneg_pkg::EFFECT_OFFS: begin
        readdata_nxt[15:0] = effective_r;
      end
      fiber_aneg_pkg::CONFIG_OFFS: begin
        readdata_nxt[fiber_aneg_pkg::MODE_LSB +: 2]  = mode_r;
        readdata_nxt[fiber_aneg_pkg::PAUSECTL_BIT]   = pauseCtl_r;
      end
      default: begin
        readdata_nxt = 32'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture

  // Straps are pins; two flops, left unreset so they settle during reset
  always_ff @(posedge clk) begin
    pauseSync1_r <= pause_strap_default;
    pauseSync2_r <= pauseSync1_r;
    anegSync1_r  <= aneg_config_strap_bit0;
    anegSync2_r  <= anegSync1_r;
  end

  // Strap values are taken on the first edge after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      strapLoad_r <= 1'h1;
    end else begin
      strapLoad_r <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and config registers

  // Software reset and restart self-clear after one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      swReset_r <= 1'h0;
      restart_r <= 1'h0;
    end else begin
      swReset_r <= wrFire && address == fiber_aneg_pkg::CTRL_OFFS && byteenable[1]
                   && writedata[fiber_aneg_pkg::SWRST_BIT];
      restart_r <= wrFire && address == fiber_aneg_pkg::CTRL_OFFS && byteenable[1]
                   && writedata[fiber_aneg_pkg::RESTART_BIT];
    end
  end

  // Power down level; kept across software reset
  always_ff @(posedge clk) begin
    if (reset) begin
      powerDown_r <= 1'h0;
    end else if (wrFire && address == fiber_aneg_pkg::CTRL_OFFS && byteenable[1]) begin
      powerDown_r <= writedata[fiber_aneg_pkg::PWRDN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r     <= fiber_aneg_pkg::MODE_RST;
      pauseCtl_r <= fiber_aneg_pkg::PAUSECTL_RST;
    end else if (wrFire && address == fiber_aneg_pkg::CONFIG_OFFS && byteenable[0]) begin
      mode_r     <= writedata[fiber_aneg_pkg::MODE_LSB +: 2];
      pauseCtl_r <= writedata[fiber_aneg_pkg::PAUSECTL_BIT];
    end
  end

  assign swResetPulse = swReset_r;
  assign restartPulse = restart_r;
  assign powerDown    = powerDown_r;

  ////////////////////////////////////////////////////////////////////////////
  // Written advertisement fields

  // Writes land only in BASE-X mode; other layouts are read-only
  assign advertWrEn = wrFire && address == fiber_aneg_pkg::ADVERT_OFFS
                      && mode_r == fiber_aneg_pkg::MODE_BASEX;
  assign advertWr   = writedata[15:0];

  // next page, hardware reset 0, software reset keeps
  always_ff @(posedge clk) begin
    if (reset) begin
      nextPage_r <= fiber_aneg_pkg::NP_RST;
    end else if (advertWrEn && byteenable[1]) begin
      nextPage_r <= advertWr[fiber_aneg_pkg::NP_BIT];
    end
  end

  // remote fault code only ever comes from software
  always_ff @(posedge clk) begin
    if (reset) begin
      remoteFault_r <= fiber_aneg_pkg::RF_RST;
    end else if (advertWrEn && byteenable[1]) begin
      remoteFault_r <= advertWr[fiber_aneg_pkg::RF_LSB +: 2];
    end
  end

  // both pause bits from the pause strap after hardware reset
  always_ff @(posedge clk) begin
    if (strapLoad_r) begin
      pauseAdv_r <= {pauseSync2_r, pauseSync2_r};
    end else if (advertWrEn) begin
      if (byteenable[1]) begin
        pauseAdv_r[1] <= advertWr[fiber_aneg_pkg::PAUSE_LSB + 1];
      end
      if (byteenable[0]) begin
        pauseAdv_r[0] <= advertWr[fiber_aneg_pkg::PAUSE_LSB];
      end
    end
  end

  // half duplex from strap bit 0 after hardware reset
  always_ff @(posedge clk) begin
    if (strapLoad_r) begin
      halfDup_r <= anegSync2_r;
    end else if (advertWrEn && byteenable[0]) begin
      halfDup_r <= advertWr[fiber_aneg_pkg::HD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fullDup_r <= fiber_aneg_pkg::FD_RST;
    end else if (advertWrEn && byteenable[0]) begin
      fullDup_r <= advertWr[fiber_aneg_pkg::FD_BIT];
    end
  end

  // Low reserved bits are writable but clear on either reset
  always_ff @(posedge clk) begin
    if (reset || swReset_r) begin
      lowBits_r <= fiber_aneg_pkg::LOW_RST;
    end else if (advertWrEn && byteenable[0]) begin
      lowBits_r <= advertWr[fiber_aneg_pkg::LOW_LSB +: 5];
    end
  end

  // bits 14 and 11:9 read zero in BASE-X layout
  always_comb begin
    writtenView = 16'h0;
    writtenView[fiber_aneg_pkg::NP_BIT]           = nextPage_r;
    writtenView[fiber_aneg_pkg::RF_LSB +: 2]      = remoteFault_r;
    writtenView[fiber_aneg_pkg::PAUSE_LSB +: 2]   = pauseAdv_r;
    writtenView[fiber_aneg_pkg::HD_BIT]           = halfDup_r;
    writtenView[fiber_aneg_pkg::FD_BIT]           = fullDup_r;
    writtenView[fiber_aneg_pkg::LOW_LSB +: 5]     = lowBits_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective copy

  apply_event_detect applyDetect (
    .clk          (clk),
    .reset        (reset),
    .swResetPulse (swReset_r),
    .restartPulse (restart_r),
    .powerDown    (powerDown_r),
    .fiberLinkUp  (fiberLinkUp),
    .applyPulse   (applyPulse)
  );

  // pending value moves over only on an apply condition
  // effective copy separate from the readable written value
  // Strap cycle also loads it, so negotiation starts from the reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      effective_r <= 16'h0;
    end else if (strapLoad_r) begin
      effective_r <= {fiber_aneg_pkg::NP_RST, 1'h0, fiber_aneg_pkg::RF_RST, 3'h0,
                      pauseSync2_r, pauseSync2_r, anegSync2_r,
                      fiber_aneg_pkg::FD_RST, fiber_aneg_pkg::LOW_RST};
    end else if (applyPulse) begin
      effective_r <= writtenView;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SGMII system image

  // link bit from copper side, resets to 0
  // pause bits gated by pause control
  // media bit gated by pause control
  always_ff @(posedge clk) begin
    if (reset) begin
      sgmiiView_r <= {9'h0, fiber_aneg_pkg::SG_LOW_FIXED};
    end else begin
      sgmiiView_r <= 16'h0;
      sgmiiView_r[fiber_aneg_pkg::SG_LINK_BIT]    <= copperLinkUp;
      sgmiiView_r[fiber_aneg_pkg::SG_DUP_BIT]     <= copperFullDuplex;
      sgmiiView_r[fiber_aneg_pkg::SG_SPD_LSB +: 2] <= copperSpeed;
      sgmiiView_r[fiber_aneg_pkg::SG_TXP_BIT]     <= copperTxPause & pauseCtl_r;
      sgmiiView_r[fiber_aneg_pkg::SG_RXP_BIT]     <= copperRxPause & pauseCtl_r;
      sgmiiView_r[fiber_aneg_pkg::SG_MEDIA_BIT]   <= fiberMediaActive & pauseCtl_r;
      sgmiiView_r[6:0]                            <= fiber_aneg_pkg::SG_LOW_FIXED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Layout selection

  // media mode reads fixed value
  // Mode 00 has no negotiation and reads zero
  always_comb begin
    case (mode_r)
      fiber_aneg_pkg::MODE_BASEX: begin
        advertRead   = writtenView;
        txConfigWord = effective_r;
      end
      fiber_aneg_pkg::MODE_SGSYS: begin
        advertRead   = sgmiiView_r;
        txConfigWord = sgmiiView_r;
      end
      fiber_aneg_pkg::MODE_SGMED: begin
        advertRead   = fiber_aneg_pkg::MEDIA_FIXED;
        txConfigWord = fiber_aneg_pkg::MEDIA_FIXED;
      end
      default: begin
        advertRead   = 16'h0;
        txConfigWord = 16'h0;
      end
    endcase
  end

  assign effectiveAdvert = effective_r;

endmodule // fiber_aneg_advert_reg

//--- verif/fiber_aneg_props.sv
// Checker for the fiber advertisement register ports
`timescale 1ns/10ps
module fiber_aneg_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire logic        pause_strap_default,
  input wire logic        aneg_config_strap_bit0,
  input wire logic        fiberLinkUp,
  input wire logic        copperLinkUp,
  input wire logic        copperFullDuplex,
  input wire logic [1:0]  copperSpeed,
  input wire logic [15:0] effectiveAdvert,
  input wire logic [15:0] txConfigWord,
  input wire logic        swResetPulse,
  input wire logic        restartPulse,
  input wire logic        powerDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] mode_r;
  logic       pctl_r;
  logic       cfgWr;
  // Shadow of mode and pause control, the config register is not visible
  assign cfgWr = write && !waitrequest && address == fiber_aneg_pkg::CONFIG_OFFS && byteenable[0];
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= fiber_aneg_pkg::MODE_RST;
      pctl_r <= fiber_aneg_pkg::PAUSECTL_RST;
    end else if (cfgWr) begin
      mode_r <= writedata[1:0];
      pctl_r <= writedata[7];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ctl;
    write && !waitrequest && address == fiber_aneg_pkg::CTRL_OFFS && byteenable[1];
  endsequence
  sequence s_once(logic s);
    s ##1 !s;
  endsequence
  property p_wait; $rose(read || write) |-> waitrequest ##1 !waitrequest; endproperty
  property p_sw; s_ctl ##0 writedata[15] |=> s_once(swResetPulse); endproperty
  property p_rs; s_ctl ##0 writedata[9] |=> s_once(restartPulse); endproperty
  property p_pd; s_ctl |=> powerDown == $past(writedata[11]); endproperty
  property p_rst;
    $fell(reset) |=> effectiveAdvert ==
      {7'h00, {2{pause_strap_default}}, aneg_config_strap_bit0, 1'h1, 5'h00};
  endproperty
  // Effective copy only moves one edge after an apply cause
  property p_apply;
    $changed(effectiveAdvert) && !$past(reset) && !$past(reset, 2) |->
      $past(swResetPulse) || $past(restartPulse) || ($past(powerDown, 2) && !$past(powerDown))
      || ($past(fiberLinkUp, 2) && !$past(fiberLinkUp));
  endproperty
  property p_media; mode_r == fiber_aneg_pkg::MODE_SGMED |-> txConfigWord == 16'h0001; endproperty
  property p_basex;
    mode_r == fiber_aneg_pkg::MODE_BASEX |->
      txConfigWord == effectiveAdvert && effectiveAdvert[14] == 1'h0 && effectiveAdvert[11:9] == 3'h0;
  endproperty
  property p_sglow;
    mode_r == fiber_aneg_pkg::MODE_SGSYS |-> txConfigWord[6:0] == 7'h01 && txConfigWord[14:13] == 2'h0;
  endproperty
  property p_sgimg;
    mode_r == fiber_aneg_pkg::MODE_SGSYS && !$past(reset) |-> txConfigWord[15] == $past(copperLinkUp)
      && txConfigWord[12] == $past(copperFullDuplex) && txConfigWord[11:10] == $past(copperSpeed);
  endproperty
  property p_sgpause;
    mode_r == fiber_aneg_pkg::MODE_SGSYS && !pctl_r && !$past(pctl_r) |-> txConfigWord[9:7] == 3'h0;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  a_sw: assert property (p_sw) else $error("reset pulse wrong");
  a_rs: assert property (p_rs) else $error("restart pulse wrong");
  a_pd: assert property (p_pd) else $error("power down wrong");
  a_rst: assert property (p_rst) else $error("reset value wrong");
  a_apply: assert property (p_apply) else $error("early apply");
  a_media: assert property (p_media) else $error("media word wrong");
  a_basex: assert property (p_basex) else $error("basex word wrong");
  a_sglow: assert property (p_sglow) else $error("fixed bits wrong");
  a_sgimg: assert property (p_sgimg) else $error("image wrong");
  a_sgpause: assert property (p_sgpause) else $error("pause not forced");
endmodule // fiber_aneg_checker

bind fiber_aneg_advert_reg fiber_aneg_checker chk (.clk, .reset, .address, .read, .write,
  .writedata, .byteenable, .waitrequest, .pause_strap_default, .aneg_config_strap_bit0,
  .fiberLinkUp, .copperLinkUp, .copperFullDuplex, .copperSpeed, .effectiveAdvert,
  .txConfigWord, .swResetPulse, .restartPulse, .powerDown);

//--- verif/link_partner_model.sv
// Link partner model: serial link state and copper status
`timescale 1ns/10ps
module link_partner_model (
  input  wire logic        clk,
  input  wire logic        linkCmd,
  input  wire logic [6:0]  statCmd,
  input  wire logic [15:0] txConfigWord,
  output logic             fiberLinkUp,
  output logic             copperLinkUp,
  output logic             copperFullDuplex,
  output logic      [1:0]  copperSpeed,
  output logic             copperTxPause,
  output logic             copperRxPause,
  output logic             fiberMediaActive,
  output logic      [15:0] rxWord
);
  // Known levels before the first edge
  initial begin
    fiberLinkUp = 1'h1;
    {copperLinkUp, copperFullDuplex, copperSpeed, copperTxPause, copperRxPause} = 6'h00;
    fiberMediaActive = 1'h0;
  end
  // One stage of lag, the far side never reacts at once
  always @(posedge clk) begin
    fiberLinkUp <= linkCmd;
    {copperLinkUp, copperFullDuplex, copperSpeed, copperTxPause, copperRxPause,
     fiberMediaActive} <= statCmd;
    rxWord <= txConfigWord;
  end
endmodule // link_partner_model

//--- verif/fiber_aneg_advert_reg_tb.sv
// Self-checking bench for the fiber advertisement register
`timescale 1ns/10ps
module fiber_aneg_advert_reg_tb;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic        pause_strap_default = 1'h1;
  logic        aneg_config_strap_bit0 = 1'h0;
  logic        linkCmd = 1'h1;
  logic [6:0]  statCmd = 7'h00;
  logic [31:0] readdata;
  logic [15:0] effectiveAdvert, txConfigWord, rxWord, effExp;
  logic [1:0]  copperSpeed;
  logic        waitrequest, fiberLinkUp, copperLinkUp, copperFullDuplex, copperTxPause;
  logic        copperRxPause, fiberMediaActive, swResetPulse, restartPulse, powerDown;
  int          errTotal = 0;
  int          numChecks = 0;

  always #25 clk = ~clk;

  fiber_aneg_advert_reg dut (.clk, .reset, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .pause_strap_default, .aneg_config_strap_bit0, .fiberLinkUp,
    .copperLinkUp, .copperFullDuplex, .copperSpeed, .copperTxPause, .copperRxPause,
    .fiberMediaActive, .effectiveAdvert, .txConfigWord, .swResetPulse, .restartPulse,
    .powerDown);
  link_partner_model partner (.clk, .linkCmd, .statCmd, .txConfigWord, .fiberLinkUp,
    .copperLinkUp, .copperFullDuplex, .copperSpeed, .copperTxPause, .copperRxPause,
    .fiberMediaActive, .rxWord);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    address <= a;
    writedata <= {16'h0000, d};
    read <= !wr;
    write <= wr;
    // Sampled at the rising edge; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'h0);
    q = readdata[15:0];
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'h0, a, 16'h0000, q);
    chk(q, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hardware reset with given strap levels
  task automatic t_hwreset(input logic p, input logic h);
    @(posedge clk);
    reset <= 1'h1;
    pause_strap_default <= p;
    aneg_config_strap_bit0 <= h;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    effExp = {7'h00, p, p, h, 1'h1, 5'h00};
    rdc(fiber_aneg_pkg::ADVERT_OFFS, effExp);
    rdc(fiber_aneg_pkg::EFFECT_OFFS, effExp);
  endtask
  // Each code written, held pending, then applied by a different cause
  task automatic t_apply;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {i[0], 1'h1, i[1:0], 3'h7, i[1:0], ~i[0], i[0], 5'h00};
      wr(fiber_aneg_pkg::ADVERT_OFFS, w);
      rdc(fiber_aneg_pkg::ADVERT_OFFS, w & 16'hb1e0);
      rdc(fiber_aneg_pkg::EFFECT_OFFS, effExp);
      case (i)
        0: wr(fiber_aneg_pkg::CTRL_OFFS, 16'h0200);
        1: begin
          wr(fiber_aneg_pkg::CTRL_OFFS, 16'h0800);
          rdc(fiber_aneg_pkg::CTRL_OFFS, 16'h0800);
          wr(fiber_aneg_pkg::CTRL_OFFS, 16'h0000);
        end
        2: begin
          @(posedge clk);
          linkCmd <= 1'h0;
          repeat (3) @(posedge clk);
          linkCmd <= 1'h1;
        end
        default: wr(fiber_aneg_pkg::CTRL_OFFS, 16'h8000);
      endcase
      effExp = w & 16'hb1e0;
      repeat (4) @(posedge clk);
      rdc(fiber_aneg_pkg::EFFECT_OFFS, effExp);
    end
    rdc(fiber_aneg_pkg::ADVERT_OFFS, effExp);
  endtask
  // Status image, pause forcing, media mode and unmapped space
  task automatic t_modes;
    logic [15:0] e;
    wr(fiber_aneg_pkg::CONFIG_OFFS, 16'h0082);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      statCmd <= i ? 7'h77 : 7'h08;
      repeat (3) @(posedge clk);
      e = i ? 16'h9b81 : 16'h0401;
      rdc(fiber_aneg_pkg::ADVERT_OFFS, e);
      chk(rxWord, e);
    end
    wr(fiber_aneg_pkg::CONFIG_OFFS, 16'h0002);
    wr(fiber_aneg_pkg::ADVERT_OFFS, 16'hffff);
    rdc(fiber_aneg_pkg::ADVERT_OFFS, 16'h9801);
    wr(fiber_aneg_pkg::CONFIG_OFFS, 16'h0003);
    rdc(fiber_aneg_pkg::ADVERT_OFFS, 16'h0001);
    rdc(5'h0c, 16'h0000);
    wr(fiber_aneg_pkg::CONFIG_OFFS, 16'h0000);
    rdc(fiber_aneg_pkg::ADVERT_OFFS, 16'h0000);
    wr(fiber_aneg_pkg::CONFIG_OFFS, 16'h0001);
    rdc(fiber_aneg_pkg::ADVERT_OFFS, effExp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_hwreset(1'h1, 1'h0);
    t_apply;
    t_modes;
    t_hwreset(1'h0, 1'h1);
    summarize;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errTotal++;
    summarize;
  end
endmodule // fiber_aneg_advert_reg_tb
